// ==== dse_entry_ctrl.sv ====
// Debug state entry control: breakpoint marks, watchpoints, debug requests
`default_nettype none
`include "dse_defs.svh"

module dse_entry_ctrl
    import dse_pkg::*;
#(
    parameter int MODE_W = `DSE_MODE_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire dse_pipe_t pipe,
    input wire logic fetch_bkpt_hit,
    input wire logic data_access,
    input wire logic data_watch_hit,
    input wire logic external_break_flag,
    input wire logic debug_request_pin,
    input wire logic comparator_req,
    input wire logic exception_pending,
    input wire logic [MODE_W-1:0] exception_mode,
    input wire logic [MODE_W-1:0] current_mode,
    input wire logic debug_resume,
    input wire logic tap_sel_load,
    input wire logic [3:0] tap_sel_value,
    input wire logic tap_capture_dr,
    input wire logic tap_shift_dr,
    input wire logic tap_update_dr,
    output logic debug_state,
    output logic mem_isolate,
    output dse_cause_t entry_cause,
    output logic [MODE_W-1:0] debug_mode,
    output logic exec_suppress,
    output logic writeback_block,
    output logic instr_abandon,
    output logic [3:0] chain_select,
    output dse_scan_t boundary_ctrl
);

    dse_state_t state_reg, state_next;
    logic mark_dec_reg, mark_dec_next;
    logic mark_exe_reg, mark_exe_next;
    logic watch_pend_reg, watch_pend_next;
    logic req_pend_reg, req_pend_next;
    logic dreq_meta_reg;
    logic dreq_sync_reg;
    dse_cause_t cause_reg, cause_next;
    logic [MODE_W-1:0] mode_reg, mode_next;
    logic abandon_reg;
    logic [3:0] chain_reg, chain_next;
    dse_scan_t bscan_reg, bscan_next;

    function automatic logic chain_known(input logic [3:0] id);
        chain_known = (id == `DSE_CHAIN_CORE_PERIPH) || (id == `DSE_CHAIN_CORE_DATA)
            || (id == `DSE_CHAIN_COMPARATOR) || (id == `DSE_CHAIN_BOUNDARY)
            || (id == `DSE_CHAIN_SYS_CTRL);
    endfunction

    // Decode of entry conditions
    wire running = (state_reg == DSE_RUN);
    wire flush = pipe.flush_branch | pipe.flush_exception;
    // Comparator hit or outside break flag, both sampled at fetch
    wire fetch_mark = fetch_bkpt_hit | external_break_flag;
    // Condition pass is deliberately not an input here
    wire bkpt_take = running & pipe.exe_valid & mark_exe_reg;
    wire watch_hit = data_access & (data_watch_hit | external_break_flag);
    wire watch_any = watch_pend_reg | watch_hit;
    wire watch_take = running & watch_any & pipe.instr_done;
    wire req_any = req_pend_reg | dreq_sync_reg | comparator_req;
    wire req_now = running & req_any & pipe.cp_busy_wait & ~bkpt_take;
    wire req_take = running & req_any & (pipe.instr_done | req_now);
    wire enter = bkpt_take | watch_take | req_take;
    wire leave = ~running & debug_resume;

    // Debug state sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DSE_RUN: begin
                if (enter) begin
                    state_next = DSE_HALT;
                end
            end
            DSE_HALT: begin
                if (debug_resume) begin
                    state_next = DSE_RUN;
                end
            end
        endcase
    end

    // Breakpoint marks travel with the instruction
    always_comb begin
        mark_dec_next = mark_dec_reg;
        mark_exe_next = mark_exe_reg;
        if (flush || enter || leave) begin
            // Flushed instructions lose their marks; refetch remarks them
            mark_dec_next = 1'b0;
            mark_exe_next = 1'b0;
        end else if (running && pipe.advance) begin
            mark_dec_next = pipe.fetch_valid & fetch_mark;
            mark_exe_next = mark_dec_reg;
        end
    end

    // Pending watchpoint and request; a hit in the taking cycle is consumed by that take
    assign watch_pend_next = (watch_pend_reg & ~watch_take) | (watch_hit & ~watch_take);
    assign req_pend_next = ((req_pend_reg | dreq_sync_reg | comparator_req) & ~req_take)
        | (~running & dreq_sync_reg & ~req_pend_reg);

    // Cause and mode captured on entry
    always_comb begin
        cause_next = cause_reg;
        mode_next = mode_reg;
        if (enter) begin
            mode_next = current_mode;
            if (bkpt_take) begin
                cause_next = DSE_CAUSE_BKPT;
            end else if (watch_take) begin
                cause_next = DSE_CAUSE_WATCH;
                if (exception_pending) begin
                    mode_next = exception_mode;
                end
            end else begin
                cause_next = DSE_CAUSE_REQ;
            end
        end
    end

    // Scan path select, loaded by the TAP; unknown numbers are ignored
    assign chain_next = (tap_sel_load && chain_known(tap_sel_value))
        ? tap_sel_value : chain_reg;
    wire bscan_on = (chain_reg == `DSE_CHAIN_BOUNDARY);
    assign bscan_next.select = bscan_on;
    assign bscan_next.capture = bscan_on & tap_capture_dr;
    assign bscan_next.shift = bscan_on & tap_shift_dr;
    assign bscan_next.update = bscan_on & tap_update_dr;

    // Pin is asynchronous: two flops before use
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dreq_meta_reg <= 1'b0;
            dreq_sync_reg <= 1'b0;
        end else begin
            dreq_meta_reg <= debug_request_pin;
            dreq_sync_reg <= dreq_meta_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= DSE_RUN;
            mark_dec_reg <= 1'b0;
            mark_exe_reg <= 1'b0;
            watch_pend_reg <= 1'b0;
            req_pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mark_dec_reg <= mark_dec_next;
            mark_exe_reg <= mark_exe_next;
            watch_pend_reg <= watch_pend_next;
            req_pend_reg <= req_pend_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cause_reg <= DSE_CAUSE_NONE;
            mode_reg <= MODE_W'(`DSE_MODE_RESET);
            abandon_reg <= 1'b0;
            chain_reg <= `DSE_CHAIN_RESET;
            bscan_reg <= '0;
        end else begin
            cause_reg <= cause_next;
            mode_reg <= mode_next;
            abandon_reg <= req_now;
            chain_reg <= chain_next;
            bscan_reg <= bscan_next;
        end
    end

    assign debug_state = state_reg;
    assign mem_isolate = state_reg;
    assign entry_cause = cause_reg;
    assign debug_mode = mode_reg;
    // Only a breakpoint stops the instruction; watchpoints let it commit
    assign exec_suppress = mark_exe_reg;
    assign writeback_block = mark_exe_reg;
    assign instr_abandon = abandon_reg;
    assign chain_select = chain_reg;
    assign boundary_ctrl = bscan_reg;

    // Checks
    bkpt_enters_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
        bkpt_take |=> debug_state && entry_cause == DSE_CAUSE_BKPT)
        else $error("breakpoint at execute did not halt");

    mark_follows_a: assert property (@(posedge clk) disable iff (sys_rst)
        running && pipe.advance && !flush && !enter && mark_dec_reg |=> mark_exe_reg)
        else $error("mark lost between stages");

    flush_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
        flush |=> !mark_dec_reg && !mark_exe_reg)
        else $error("mark survived a flush");

    no_early_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
        running && !pipe.instr_done && !pipe.cp_busy_wait && !(pipe.exe_valid && mark_exe_reg)
        |=> !debug_state)
        else $error("debug entered with no trigger");

    watch_kept_a: assert property (@(posedge clk) disable iff (sys_rst)
        running && watch_hit && !pipe.instr_done |=> watch_pend_reg)
        else $error("watchpoint dropped");

    watch_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
        watch_take && !bkpt_take && exception_pending
        |=> debug_mode == $past(exception_mode))
        else $error("wrong mode after watchpoint");

    sync_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
        debug_request_pin [*3] |-> dreq_sync_reg)
        else $error("request pin not synchronised in two cycles");

    busy_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
        running && req_any && pipe.cp_busy_wait && !bkpt_take
        |=> debug_state && instr_abandon ##1 !instr_abandon)
        else $error("busy-wait not abandoned at once");

    halt_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
        debug_state && !debug_resume |=> debug_state && mem_isolate)
        else $error("debug state dropped without resume");

    resume_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
        debug_state && debug_resume |=> !debug_state && !mem_isolate)
        else $error("resume did not leave debug state");

    suppress_tied_a: assert property (@(posedge clk) disable iff (sys_rst)
        pipe.exe_valid && exec_suppress && running |=> debug_state)
        else $error("suppressed instruction without entry");

    boundary_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        chain_select == `DSE_CHAIN_BOUNDARY && tap_shift_dr |=> boundary_ctrl.shift)
        else $error("boundary chain shift missing");

    exc_flush_a: assert property (@(posedge clk) disable iff (sys_rst)
        pipe.flush_exception |=> !mark_dec_reg && !mark_exe_reg)
        else $error("mark survived an exception flush");

    entry_unmarks_a: assert property (@(posedge clk) disable iff (sys_rst)
        enter |=> !exec_suppress && !writeback_block)
        else $error("mark kept after debug entry");

    watch_commits_a: assert property (@(posedge clk) disable iff (sys_rst)
        watch_take && !bkpt_take && pipe.exe_valid |-> !writeback_block)
        else $error("watchpointed instruction blocked");

    req_at_end_a: assert property (@(posedge clk) disable iff (sys_rst)
        running && req_any && pipe.instr_done && !bkpt_take && !watch_any
        |=> debug_state && entry_cause == DSE_CAUSE_REQ)
        else $error("request not taken at instruction end");

    entry_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
        bkpt_take |=> debug_mode == $past(current_mode))
        else $error("wrong mode after breakpoint");

    abandon_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
        instr_abandon |-> debug_state && $past(pipe.cp_busy_wait))
        else $error("abandon without busy-wait");

    chain_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
        tap_sel_load && !chain_known(tap_sel_value) |=> $stable(chain_select))
        else $error("unknown chain number was loaded");

    cover_abort_c: cover property (@(posedge clk) disable iff (sys_rst)
        req_now ##1 instr_abandon);
    cover_bkpt_c: cover property (@(posedge clk) disable iff (sys_rst)
        running && pipe.exe_valid && mark_exe_reg ##1 debug_state);
    cover_watch_c: cover property (@(posedge clk) disable iff (sys_rst)
        watch_hit && !pipe.instr_done ##[1:20] watch_take);
    cover_req_c: cover property (@(posedge clk) disable iff (sys_rst)
        req_take && pipe.instr_done ##1 entry_cause == DSE_CAUSE_REQ);
    cover_flush_c: cover property (@(posedge clk) disable iff (sys_rst)
        mark_dec_reg && pipe.flush_branch);

endmodule // dse_entry_ctrl
`default_nettype wire

// ==== dse_defs.svh ====
// Constants for the debug state entry control block
`ifndef DSE_DEFS_SVH
`define DSE_DEFS_SVH

// Scan chain numbers
`define DSE_CHAIN_CORE_PERIPH 4'h0
`define DSE_CHAIN_CORE_DATA 4'h1
`define DSE_CHAIN_COMPARATOR 4'h2
`define DSE_CHAIN_BOUNDARY 4'h3
`define DSE_CHAIN_SYS_CTRL 4'hf

// Reset values
`define DSE_CHAIN_RESET 4'h3
`define DSE_MODE_RESET 5'h13

// Width of processor mode field
`define DSE_MODE_W 5

`endif

// ==== dse_pkg.sv ====
// Types shared by the debug state entry control block
`default_nettype none
package dse_pkg;

    typedef enum logic [0:0] {
        DSE_RUN = 1'b0,
        DSE_HALT = 1'b1
    } dse_state_t;

    typedef enum logic [1:0] {
        DSE_CAUSE_NONE = 2'b00,
        DSE_CAUSE_BKPT = 2'b01,
        DSE_CAUSE_WATCH = 2'b10,
        DSE_CAUSE_REQ = 2'b11
    } dse_cause_t;

    // Pipeline status from the core
    typedef struct packed {
        logic fetch_valid;
        logic advance;
        logic flush_branch;
        logic flush_exception;
        logic exe_valid;
        logic instr_done;
        logic cp_busy_wait;
    } dse_pipe_t;

    // Control lines for the optional external boundary chain
    typedef struct packed {
        logic select;
        logic capture;
        logic shift;
        logic update;
    } dse_scan_t;

endpackage : dse_pkg
`default_nettype wire

// ==== dse_partner.sv ====
// Far-side model: comparator unit and external debug logic
`default_nettype none
module dse_partner
    import dse_pkg::*;
(
    input wire dse_pipe_t pipe,
    input wire logic data_access,
    input wire logic [4:0] en,
    output logic fetch_bkpt_hit,
    output logic data_watch_hit,
    output logic external_break_flag,
    output logic comparator_req,
    output logic debug_request_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // The fetch and data comparators only fire while the matching bus activity is present
    assign fetch_bkpt_hit = en[0] & pipe.fetch_valid;
    assign data_watch_hit = en[1] & data_access;
    assign external_break_flag = en[2];
    assign comparator_req = en[3];
    // Pin level is changed off the core clock only by the bench edge
    assign debug_request_pin = en[4];
endmodule // dse_partner
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the debug state entry control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dse_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    dse_pipe_t pipe = '0;
    logic data_access = 1'b0;
    logic [4:0] en = 5'h0;
    logic exception_pending = 1'b0;
    logic [4:0] exception_mode = 5'h0;
    logic [4:0] current_mode = 5'h0;
    logic debug_resume = 1'b0;
    logic tap_sel_load = 1'b0;
    logic [3:0] tap_sel_value = 4'h0;
    logic [2:0] tap_dr = 3'h0;
    logic debug_state, mem_isolate, exec_suppress, writeback_block, instr_abandon;
    dse_cause_t entry_cause;
    logic [4:0] debug_mode;
    logic [3:0] chain_select;
    dse_scan_t boundary_ctrl;
    logic f_hit, w_hit, x_brk, c_req, pin;
    logic [3:0] chains [6] = '{4'h0, 4'h1, 4'h2, 4'hf, 4'h5, 4'h3};
    int n_fail = 0;
    int n_compared = 0;

    always #50 clk = ~clk;

    dse_partner partner (.pipe(pipe), .data_access(data_access), .en(en),
        .fetch_bkpt_hit(f_hit), .data_watch_hit(w_hit), .external_break_flag(x_brk),
        .comparator_req(c_req), .debug_request_pin(pin));

    dse_entry_ctrl dut (.clk(clk), .sys_rst(sys_rst), .pipe(pipe), .fetch_bkpt_hit(f_hit),
        .data_access(data_access), .data_watch_hit(w_hit), .external_break_flag(x_brk),
        .debug_request_pin(pin), .comparator_req(c_req),
        .exception_pending(exception_pending), .exception_mode(exception_mode),
        .current_mode(current_mode), .debug_resume(debug_resume),
        .tap_sel_load(tap_sel_load), .tap_sel_value(tap_sel_value),
        .tap_capture_dr(tap_dr[2]), .tap_shift_dr(tap_dr[1]), .tap_update_dr(tap_dr[0]),
        .debug_state(debug_state), .mem_isolate(mem_isolate), .entry_cause(entry_cause),
        .debug_mode(debug_mode), .exec_suppress(exec_suppress),
        .writeback_block(writeback_block), .instr_abandon(instr_abandon),
        .chain_select(chain_select), .boundary_ctrl(boundary_ctrl));

    task automatic conclude();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Entry latency differs by trigger, so allow a short bounded wait
    task automatic wait_ds();
        for (int i = 0; i < 4 && debug_state !== 1'b1; i++) @(negedge clk);
        if (debug_state !== 1'b1) begin
            n_fail++;
            conclude();
        end
    endtask

    task automatic resume();
        @(posedge clk);
        debug_resume <= 1'b1;
        @(posedge clk);
        debug_resume <= 1'b0;
        @(negedge clk);
        chk(debug_state, 1'b0);
        chk(mem_isolate, 1'b0);
    endtask

    task automatic reset_check();
        chk(debug_state, 1'b0);
        chk(mem_isolate, 1'b0);
        chk(debug_mode, 5'h13);
        chk(chain_select, 4'h3);
        chk(boundary_ctrl, 4'h0);
        chk(entry_cause, DSE_CAUSE_NONE);
        chk(exec_suppress, 1'b0);
        chk(instr_abandon, 1'b0);
    endtask

    task automatic chain_sel();
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            tap_sel_load <= 1'b1;
            tap_sel_value <= chains[k];
            @(posedge clk);
            tap_sel_load <= 1'b0;
            @(negedge clk);
            chk(chain_select, (chains[k] == 4'h5) ? 4'hf : chains[k]);
        end
        @(posedge clk);
        tap_dr <= 3'h7;
        @(posedge clk);
        tap_dr <= 3'h0;
        @(negedge clk);
        chk(boundary_ctrl, 4'hf);
        @(negedge clk);
        chk(boundary_ctrl, 4'h8);
    endtask

    task automatic bkpt(input logic [4:0] src);
        @(posedge clk);
        pipe <= 7'h60;
        en <= src;
        current_mode <= 5'h1f;
        @(posedge clk);
        pipe <= 7'h20;
        en <= 5'h0;
        @(posedge clk);
        pipe <= 7'h04;
        @(negedge clk);
        chk(exec_suppress, 1'b1);
        chk(writeback_block, 1'b1);
        chk(debug_state, 1'b0);
        @(posedge clk);
        pipe <= 7'h00;
        @(negedge clk);
        chk(debug_state, 1'b1);
        chk(mem_isolate, 1'b1);
        chk(entry_cause, DSE_CAUSE_BKPT);
        chk(debug_mode, 5'h1f);
        chk(exec_suppress, 1'b0);
        resume();
    endtask

    task automatic flush_cancel();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            pipe <= 7'h60;
            en <= 5'h01;
            @(posedge clk);
            pipe <= (k == 0) ? 7'h10 : 7'h08;
            en <= 5'h0;
            // Advance after the flush so a surviving mark would reach execute
            @(posedge clk);
            pipe <= 7'h20;
            @(posedge clk);
            pipe <= 7'h04;
            @(negedge clk);
            chk(exec_suppress, 1'b0);
            @(posedge clk);
            pipe <= 7'h00;
            @(negedge clk);
            chk(debug_state, 1'b0);
        end
        bkpt(5'h04);
    endtask

    task automatic watch();
        @(posedge clk);
        pipe <= 7'h04;
        data_access <= 1'b1;
        en <= 5'h02;
        current_mode <= 5'h10;
        exception_mode <= 5'h11;
        @(posedge clk);
        data_access <= 1'b0;
        en <= 5'h0;
        // Multi-word transfer still running: entry must wait
        repeat (4) begin
            @(negedge clk);
            chk(debug_state, 1'b0);
        end
        @(posedge clk);
        exception_pending <= 1'b1;
        pipe <= 7'h06;
        @(posedge clk);
        pipe <= 7'h00;
        @(negedge clk);
        wait_ds();
        chk(entry_cause, DSE_CAUSE_WATCH);
        chk(debug_mode, 5'h11);
        chk(writeback_block, 1'b0);
        @(posedge clk);
        exception_pending <= 1'b0;
        resume();
    endtask

    task automatic request();
        logic ab;
        @(posedge clk);
        pipe <= 7'h06;
        en <= 5'h08;
        @(posedge clk);
        pipe <= 7'h00;
        en <= 5'h0;
        @(negedge clk);
        wait_ds();
        chk(entry_cause, DSE_CAUSE_REQ);
        chk(instr_abandon, 1'b0);
        resume();
        @(posedge clk);
        pipe <= 7'h04;
        en <= 5'h10;
        repeat (4) begin
            @(negedge clk);
            chk(debug_state, 1'b0);
        end
        @(posedge clk);
        pipe <= 7'h05;
        @(negedge clk);
        wait_ds();
        ab = instr_abandon;
        @(negedge clk);
        ab = ab | instr_abandon;
        chk(ab, 1'b1);
        chk(entry_cause, DSE_CAUSE_REQ);
        @(posedge clk);
        pipe <= 7'h00;
        en <= 5'h0;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        reset_check();
        chain_sel();
        bkpt(5'h01);
        flush_cancel();
        watch();
        request();
        // Reset again while halted: everything must return to its reset value
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        reset_check();
        conclude();
    end
endmodule // tb
`default_nettype wire
